// ---- icf_defs.vh ----
// Constants for the image chunk trailer framer
`ifndef ICF_DEFS_VH
`define ICF_DEFS_VH
// Register byte offsets
`define ICF_OFF_CTRL 8'h00
`define ICF_OFF_PICK 8'h04
`define ICF_OFF_ITEM_ON 8'h08
`define ICF_OFF_ITEM_MASK 8'h0C
`define ICF_OFF_FC_RESET 8'h10
`define ICF_OFF_FRAME_COUNT 8'h14
`define ICF_OFF_STAMP_LO 8'h18
`define ICF_OFF_STAMP_HI 8'h1C
`define ICF_OFF_STATUS 8'h20
// Field positions
`define ICF_BIT_MASTER 0
`define ICF_BIT_ITEM_ON 0
`define ICF_BIT_SW_RESET 8
// Counter reset sources
`define ICF_FCSRC_OFF 2'h0
`define ICF_FCSRC_LINE1 2'h1
`define ICF_FCSRC_SW 2'h2
// Item indices, in trailer order
`define ICF_ITEM_EXT 3'h0
`define ICF_ITEM_GAIN 3'h1
`define ICF_ITEM_LINES 3'h2
`define ICF_ITEM_EXPO 3'h3
`define ICF_ITEM_STAMP 3'h4
`define ICF_ITEM_FCNT 3'h5
`define ICF_ITEM_NONE 3'h7
`define ICF_NUM_ITEMS 6
// Chunk identifiers, upper half of header word
`define ICF_ID_BASE 16'hC000
// Payload lengths in words
`define ICF_LEN_EXT 4'h4
`define ICF_LEN_STAMP 4'h2
`define ICF_LEN_ONE 4'h1
// Reset values, and the item enables loaded when the switch turns on
`define ICF_RST_ITEMS 6'h00
`define ICF_ON_ITEMS 6'h01
`define ICF_RST_FCSRC 2'h0
`define ICF_RST_WORD 32'h0000_0000
// Timing
`define ICF_CLK_PERIOD_NS 6'h19
`define ICF_TICK_NS 6'h08
`endif

// ---- icf_stamp_clock.v ----
// Free-running 64-bit timestamp counter in 8 ns ticks
`timescale 1ns/10ps
`include "icf_defs.vh"
module icf_stamp_clock (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Current tick count
  output reg [63:0] stamp_ticks
);
  // Nanoseconds per clock and per tick
  localparam [5:0] STEP_NS = `ICF_CLK_PERIOD_NS;
  localparam [5:0] TICK_NS = `ICF_TICK_NS;
  // Leftover nanoseconds not yet a whole tick
  reg [5:0] residue_ns;
  // Time elapsed including leftover
  wire [5:0] sum_ns;
  // Whole ticks covered this cycle
  wire [5:0] whole_ticks;
  // Next leftover
  wire [5:0] next_residue;
  assign sum_ns = residue_ns + STEP_NS;
  assign whole_ticks = sum_ns / TICK_NS;
  assign next_residue = sum_ns % TICK_NS;
  // The clock is slower than the tick, so several ticks are added per
  // cycle; the residue keeps the long-run rate exact with no drift.
  always @(posedge clk)
  begin
    if (rst)
    begin
      stamp_ticks <= 64'h0000_0000_0000_0000;
      residue_ns <= 6'h00;
    end
    else
    begin
      stamp_ticks <= stamp_ticks + {58'h0, whole_ticks};
      residue_ns <= next_residue;
    end
  end
endmodule // icf_stamp_clock

// ---- icf_framer.v ----
// Image chunk trailer framer: appends metadata chunks after image data
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "icf_defs.vh"
module icf_framer (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Acquisition trigger, one cycle
  input wire frame_start,
  // Acquisition settings in effect
  input wire [15:0] roi_x_off,
  input wire [15:0] roi_y_off,
  input wire [15:0] roi_width,
  input wire [15:0] roi_height,
  input wire [31:0] pixel_format,
  input wire [15:0] dyn_min,
  input wire [15:0] dyn_max,
  input wire [31:0] overall_gain_value,
  input wire [31:0] shutter_duration,
  input wire [7:0] io_line_levels,
  // Image stream from pipeline
  input wire img_valid,
  input wire [31:0] img_data,
  input wire img_last,
  output reg img_ready,
  // Stream toward host
  output reg tx_valid,
  output reg [31:0] tx_data,
  output reg tx_last,
  output reg tx_trailer,
  output reg transfer_content_kind
);
  // Framer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PIX = 2'h1;
  localparam [1:0] ST_TRL = 2'h2;

  // Payload words of one item
  function [3:0] item_len;
    input [2:0] item;
    begin
      case (item)
        `ICF_ITEM_EXT: item_len = `ICF_LEN_EXT;
        `ICF_ITEM_STAMP: item_len = `ICF_LEN_STAMP;
        default: item_len = `ICF_LEN_ONE;
      endcase
    end
  endfunction

  // First enabled item at or after a start index
  function [2:0] next_item;
    input [5:0] mask;
    input [2:0] from;
    integer i;
    reg found;
    begin
      found = 1'b0;
      next_item = `ICF_ITEM_NONE;
      for (i = 0; i < `ICF_NUM_ITEMS; i = i + 1)
      begin
        if (!found && i >= from && mask[i])
        begin
          next_item = i[2:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // Software settings
  reg trailer_master_on;
  reg [2:0] trailer_item_pick;
  reg [5:0] trailer_item_on;
  reg [1:0] fc_reset_src;
  // Live counters
  reg [31:0] image_count;
  wire [63:0] stamp_now;
  // Previous line 1 level, for edge detection
  reg line1_prev;
  // Per-acquisition snapshot, taken at the trigger
  reg [63:0] acq_stamp;
  reg [31:0] acq_count;
  reg [31:0] acq_gain;
  reg [31:0] acq_shutter;
  reg [7:0] acq_lines;
  reg [63:0] acq_roi;
  reg [31:0] acq_fmt;
  reg [31:0] acq_dyn;
  reg [5:0] acq_mask;
  reg acq_master;
  // Snapshot of the frame being sent
  reg [63:0] tx_stamp;
  reg [31:0] tx_count;
  reg [31:0] tx_gain;
  reg [31:0] tx_shutter;
  reg [7:0] tx_lines;
  reg [63:0] tx_roi;
  reg [31:0] tx_fmt;
  reg [31:0] tx_dyn;
  reg [5:0] tx_mask;
  reg tx_master;
  // Framer sequencing
  reg [1:0] state;
  reg [2:0] cur_item;
  reg [3:0] word_idx;
  // Trailer word for current position
  reg [31:0] trl_word;
  // Decoded events
  wire pix_take;
  wire line1_rise;
  wire sw_reset;
  wire fc_clear;
  wire [2:0] first_item;
  wire [2:0] after_item;
  wire chunk_done;

  // Timestamp source
  icf_stamp_clock u_stamp (
    .clk(clk),
    .rst(rst),
    .stamp_ticks(stamp_now)
  );

  assign pix_take = img_valid && img_ready;
  assign line1_rise = io_line_levels[0] && !line1_prev;
  assign sw_reset = reg_wr && (reg_addr == `ICF_OFF_FC_RESET) &&
                    reg_wdata[`ICF_BIT_SW_RESET];
  assign fc_clear = ((fc_reset_src == `ICF_FCSRC_LINE1) && line1_rise) ||
                    ((fc_reset_src == `ICF_FCSRC_SW) && sw_reset);
  assign first_item = next_item(tx_mask, 3'h0);
  assign after_item = next_item(tx_mask, cur_item + 3'h1);
  assign chunk_done = (word_idx == item_len(cur_item));

  // Software settings and item enables
  always @(posedge clk)
  begin
    if (rst)
    begin
      trailer_master_on <= 1'b0;
      trailer_item_pick <= 3'h0;
      trailer_item_on <= `ICF_RST_ITEMS;
      fc_reset_src <= `ICF_RST_FCSRC;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ICF_OFF_CTRL:
        begin
          trailer_master_on <= reg_wdata[`ICF_BIT_MASTER];
          if (!reg_wdata[`ICF_BIT_MASTER])
            trailer_item_on <= `ICF_RST_ITEMS;
          else if (!trailer_master_on)
            trailer_item_on <= `ICF_ON_ITEMS;
        end
        `ICF_OFF_PICK: trailer_item_pick <= reg_wdata[2:0];
        `ICF_OFF_ITEM_ON:
        begin
          if (trailer_master_on && trailer_item_pick < `ICF_NUM_ITEMS)
            trailer_item_on[trailer_item_pick] <= reg_wdata[`ICF_BIT_ITEM_ON];
        end
        `ICF_OFF_FC_RESET: fc_reset_src <= reg_wdata[1:0];
        default: trailer_master_on <= trailer_master_on;
      endcase
    end
  end

  // Acquired-image counter and trigger snapshot
  always @(posedge clk)
  begin
    if (rst)
    begin
      image_count <= `ICF_RST_WORD;
      line1_prev <= 1'b0;
      acq_stamp <= 64'h0000_0000_0000_0000;
      acq_count <= `ICF_RST_WORD;
      acq_gain <= `ICF_RST_WORD;
      acq_shutter <= `ICF_RST_WORD;
      acq_lines <= 8'h00;
      acq_roi <= 64'h0000_0000_0000_0000;
      acq_fmt <= `ICF_RST_WORD;
      acq_dyn <= `ICF_RST_WORD;
      acq_mask <= `ICF_RST_ITEMS;
      acq_master <= 1'b0;
    end
    else
    begin
      line1_prev <= io_line_levels[0];
      // Reset beats a trigger in the same cycle
      if (fc_clear)
        image_count <= `ICF_RST_WORD;
      else if (frame_start)
        image_count <= image_count + 32'h0000_0001;
      if (frame_start)
      begin
        acq_stamp <= stamp_now;
        acq_count <= image_count;
        acq_gain <= overall_gain_value;
        acq_shutter <= shutter_duration;
        acq_lines <= io_line_levels;
        acq_roi <= {roi_x_off, roi_y_off, roi_width, roi_height};
        acq_fmt <= pixel_format;
        acq_dyn <= {dyn_min, dyn_max};
        acq_mask <= trailer_master_on ? trailer_item_on : `ICF_RST_ITEMS;
        acq_master <= trailer_master_on;
      end
    end
  end

  // Trailer word mux; header is identifier and payload length
  always @*
  begin
    trl_word = `ICF_RST_WORD;
    if (word_idx == 4'h0)
      trl_word = {`ICF_ID_BASE | {13'h0, cur_item}, 12'h000, item_len(cur_item)};
    else
    begin
      case (cur_item)
        `ICF_ITEM_EXT:
        begin
          case (word_idx)
            4'h1: trl_word = tx_roi[63:32];
            4'h2: trl_word = tx_roi[31:0];
            4'h3: trl_word = tx_fmt;
            default: trl_word = tx_dyn;
          endcase
        end
        `ICF_ITEM_GAIN: trl_word = tx_gain;
        `ICF_ITEM_LINES: trl_word = {24'h00_0000, tx_lines};
        `ICF_ITEM_EXPO: trl_word = tx_shutter;
        // Low word first
        `ICF_ITEM_STAMP: trl_word = (word_idx == 4'h1) ? tx_stamp[31:0] : tx_stamp[63:32];
        `ICF_ITEM_FCNT: trl_word = tx_count;
        default: trl_word = `ICF_RST_WORD;
      endcase
    end
  end

  // Frame sequencing: pixels pass through, then the trailer follows.
  // No buffering: the pipeline is held off while the trailer goes out.
  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cur_item <= 3'h0;
      word_idx <= 4'h0;
      img_ready <= 1'b1;
      tx_valid <= 1'b0;
      tx_data <= `ICF_RST_WORD;
      tx_last <= 1'b0;
      tx_trailer <= 1'b0;
      transfer_content_kind <= 1'b0;
      tx_stamp <= 64'h0000_0000_0000_0000;
      tx_count <= `ICF_RST_WORD;
      tx_gain <= `ICF_RST_WORD;
      tx_shutter <= `ICF_RST_WORD;
      tx_lines <= 8'h00;
      tx_roi <= 64'h0000_0000_0000_0000;
      tx_fmt <= `ICF_RST_WORD;
      tx_dyn <= `ICF_RST_WORD;
      tx_mask <= `ICF_RST_ITEMS;
      tx_master <= 1'b0;
    end
    else
    begin
      // Default: nothing sent this cycle
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_trailer <= 1'b0;
      case (state)
        ST_IDLE, ST_PIX:
        begin
          // Track the newest trigger until the frame begins
          if (state == ST_IDLE)
          begin
            tx_stamp <= acq_stamp;
            tx_count <= acq_count;
            tx_gain <= acq_gain;
            tx_shutter <= acq_shutter;
            tx_lines <= acq_lines;
            tx_roi <= acq_roi;
            tx_fmt <= acq_fmt;
            tx_dyn <= acq_dyn;
            tx_mask <= acq_mask;
            tx_master <= acq_master;
          end
          if (pix_take)
          begin
            tx_valid <= 1'b1;
            tx_data <= img_data;
            transfer_content_kind <= (state == ST_IDLE) ? acq_master : tx_master;
            state <= ST_PIX;
            if (img_last)
            begin
              if (first_item != `ICF_ITEM_NONE && state == ST_PIX)
              begin
                img_ready <= 1'b0;
                cur_item <= first_item;
                word_idx <= 4'h0;
                state <= ST_TRL;
              end
              else
              begin
                // Plain image or one-word frame ends here
                tx_last <= 1'b1;
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_TRL:
        begin
          tx_valid <= 1'b1;
          tx_trailer <= 1'b1;
          tx_data <= trl_word;
          transfer_content_kind <= tx_master;
          if (!chunk_done)
            word_idx <= word_idx + 4'h1;
          else if (after_item == `ICF_ITEM_NONE)
          begin
            tx_last <= 1'b1;
            img_ready <= 1'b1;
            state <= ST_IDLE;
          end
          else
          begin
            cur_item <= after_item;
            word_idx <= 4'h0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          img_ready <= 1'b1;
        end
      endcase
    end
  end

  // Register read, data one cycle after the strobe
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata <= `ICF_RST_WORD;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ICF_OFF_CTRL: reg_rdata <= {31'h0, trailer_master_on};
        `ICF_OFF_PICK: reg_rdata <= {29'h0, trailer_item_pick};
        `ICF_OFF_ITEM_ON:
          reg_rdata <= (trailer_item_pick < `ICF_NUM_ITEMS) ?
                       {31'h0, trailer_item_on[trailer_item_pick]} : `ICF_RST_WORD;
        `ICF_OFF_ITEM_MASK: reg_rdata <= {26'h0, trailer_item_on};
        `ICF_OFF_FC_RESET: reg_rdata <= {30'h0, fc_reset_src};
        `ICF_OFF_FRAME_COUNT: reg_rdata <= image_count;
        `ICF_OFF_STAMP_LO: reg_rdata <= stamp_now[31:0];
        `ICF_OFF_STAMP_HI: reg_rdata <= stamp_now[63:32];
        `ICF_OFF_STATUS: reg_rdata <= {29'h0, transfer_content_kind, state};
        // Unmapped reads return zero
        default: reg_rdata <= `ICF_RST_WORD;
      endcase
    end
    else
      reg_rdata <= `ICF_RST_WORD;
  end
endmodule // icf_framer

// ---- icf_framer_properties.sv ----
// Port-level checker for the chunk trailer framer
`timescale 1ns/10ps
module icf_framer_properties (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Acquisition and image stream
  input wire frame_start,
  input wire img_valid,
  input wire [31:0] img_data,
  input wire img_last,
  input wire img_ready,
  // Stream toward host
  input wire tx_valid,
  input wire [31:0] tx_data,
  input wire tx_last,
  input wire tx_trailer,
  input wire transfer_content_kind
);
  // Live switch, switch taken at the trigger, switch of the frame in flight
  reg mo;
  reg fa;
  reg fm;
  // High between a frame's first and last pixel word
  reg busy;
  // Switch that governs the pixel word taken now
  wire cur_m;
  assign cur_m = busy ? fm : fa;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Follow software writes; trigger copy is taken at the trigger, frame copy at the frame's first pixel word
  always @(posedge clk)
    if (rst)
    begin
      mo <= 1'b0;
      fa <= 1'b0;
      fm <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h00)
        mo <= reg_wdata[0];
      if (frame_start)
        fa <= mo;
      // A trigger may arrive mid-frame, so the frame keeps its own copy
      if (img_valid && img_ready)
      begin
        if (!busy)
          fm <= fa;
        busy <= !img_last;
      end
    end
  switch_readback_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == {31'h0, mo})
    else $error("switch readback wrong");
  mask_cleared_a: assert property (reg_rd && reg_addr == 8'h0C && !mo |=> reg_rdata == 32'h0)
    else $error("item mask not clear");
  pixel_pass_a: assert property (img_valid && img_ready |=> tx_valid && !tx_trailer
    && tx_data == $past(img_data))
    else $error("pixel word not passed");
  trailer_hold_a: assert property (tx_trailer && !tx_last |-> !img_ready)
    else $error("pixels taken during trailer");
  kind_mark_a: assert property (tx_valid |-> transfer_content_kind == fm)
    else $error("content kind wrong");
  off_plain_a: assert property (!cur_m && img_valid && img_ready && img_last
    |=> tx_last ##1 !tx_trailer)
    else $error("trailer with switch off");
  ext_first_a: assert property (fm && busy && img_valid && img_ready && img_last
    |=> !tx_last ##1 tx_trailer && tx_data == 32'hC000_0004)
    else $error("extended chunk not first");
  ext_length_a: assert property (tx_trailer && tx_data == 32'hC000_0004
    |=> (tx_valid && tx_trailer) [*4])
    else $error("extended chunk short");
  trailer_frame_c: cover property (tx_last && tx_trailer);
  plain_frame_c: cover property (tx_last && !tx_trailer);
  mask_read_c: cover property (reg_rd && reg_addr == 8'h0C);
endmodule // icf_framer_properties

bind icf_framer icf_framer_properties chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .frame_start(frame_start), .img_valid(img_valid), .img_data(img_data),
  .img_last(img_last), .img_ready(img_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_trailer(tx_trailer), .transfer_content_kind(transfer_content_kind));

// ---- icf_host_sink.sv ----
// Host-side sink model collecting each transmitted transfer
`timescale 1ns/10ps
module icf_host_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stream from the framer
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_trailer,
  input wire logic kind
);
  // Words, trailer words, transfers seen, last content kind
  logic [31:0] q[$];
  int ntr = 0;
  int nfr = 0;
  logic lk = 1'b0;
  // host takes items
  // No backpressure exists, so every valid word is taken at once
  always @(posedge clk)
    if (!rst && tx_valid)
    begin
      q.push_back(tx_data);
      ntr = ntr + int'(tx_trailer);
      lk = kind;
      if (tx_last)
        nfr = nfr + 1;
    end
endmodule // icf_host_sink

// ---- icf_framer_tb.sv ----
// Self-checking bench for the chunk trailer framer
`timescale 1ns/10ps
module icf_framer_tb;
  // Clock, reset and register port
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  // Acquisition settings and image stream
  logic frame_start = 1'b0;
  logic img_valid = 1'b0;
  logic img_last = 1'b0;
  logic img_ready;
  logic [31:0] img_data = 32'h0000_0000;
  logic [15:0] s = 16'h0000;
  logic [7:0] lines = 8'hA4;
  // Host-bound stream
  logic tx_valid, tx_last, tx_trailer, kind;
  logic [31:0] tx_data;
  // Counters and expected state of the switch, mask and frame count
  int err_count = 0, total_checks = 0, cyc = 0, tick = 0, fx = 0, i;
  logic mm = 1'b0;
  logic [5:0] mk = 6'h00;
  logic [31:0] ex[$];

  icf_framer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .roi_x_off(s), .roi_y_off(s ^ 16'h00FF), .roi_width(s + 16'h0100),
    .roi_height(s + 16'h0200), .pixel_format({s, s}), .dyn_min(~s), .dyn_max(s),
    .overall_gain_value({16'h0001, s}), .shutter_duration({16'h0000, s}),
    .io_line_levels(lines), .img_valid(img_valid), .img_data(img_data),
    .img_last(img_last), .img_ready(img_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_trailer(tx_trailer), .transfer_content_kind(kind));
  icf_host_sink host (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_trailer(tx_trailer), .kind(kind));

  // Clock of 25 ns period
  initial
    forever #12.5 clk = ~clk;

  // Cycles since reset release, and a ceiling against hangs
  always @(posedge clk)
  begin
    tick <= tick + 1;
    cyc <= rst ? 0 : cyc + 1;
    if (tick > 5000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // Chunk header word, optionally followed by one payload word
  task automatic hdr(input logic [2:0] n, input logic [3:0] l);
    ex.push_back({16'hC000 | {13'h0000, n}, 12'h000, l});
  endtask
  task automatic put(input logic [2:0] n, input logic [31:0] w);
    hdr(n, 4'h1);
    ex.push_back(w);
  endtask

  // One acquisition of n pixel words, then the transfer is compared
  task automatic frame(input int n);
    int k, sp, f0;
    longint d;
    logic [15:0] v;
    v = 16'h0010 + 16'(fx);
    sp = -1;
    @(posedge clk);
    frame_start <= 1'b1;
    s <= v;
    @(posedge clk);
    frame_start <= 1'b0;
    // Settings change after the trigger must not leak into the chunks
    s <= 16'hDEAD;
    d = longint'(cyc) * 25 / 8;
    ex.delete();
    host.q.delete();
    host.ntr = 0;
    f0 = host.nfr;
    for (k = 0; k < n; k++)
      ex.push_back(32'h0000_1000 + k);
    if (mm && n > 1)
    begin
      if (mk[0])
      begin
        hdr(3'h0, 4'h4);
        ex.push_back({v, v ^ 16'h00FF});
        ex.push_back({v + 16'h0100, v + 16'h0200});
        ex.push_back({v, v});
        ex.push_back({~v, v});
      end
      if (mk[1])
        put(3'h1, {16'h0001, v});
      if (mk[2])
        put(3'h2, {24'h00_0000, lines});
      if (mk[3])
        put(3'h3, {16'h0000, v});
      if (mk[4])
      begin
        hdr(3'h4, 4'h2);
        sp = ex.size();
        ex.push_back(32'h0000_0000);
        ex.push_back(32'h0000_0000);
      end
      if (mk[5])
        put(3'h5, 32'(fx));
    end
    for (k = 0; k < n; k++)
    begin
      img_valid <= 1'b1;
      img_data <= ex[k];
      img_last <= (k == n - 1);
      @(posedge clk);
    end
    img_valid <= 1'b0;
    img_last <= 1'b0;
    for (k = 0; k < 64 && host.nfr == f0; k++)
      @(posedge clk);
    @(posedge clk);
    chk(host.q.size(), ex.size());
    chk(host.ntr, ex.size() - n);
    chk(host.lk, mm);
    for (k = 0; k < ex.size(); k++)
      if (k != sp && k != sp + 1)
        chk(host.q[k], ex[k]);
    // Only frames that carry the stamp item hold its two words
    if (sp > 0)
    begin
      d = longint'({host.q[sp + 1], host.q[sp]}) - d;
      chk(32'(d > -12 && d < 12), 32'h1);
    end
    fx++;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    wr(8'h08, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
    frame(3);
    $display("test master off done");
    wr(8'h00, 32'h0000_0001);
    mm = 1'b1;
    mk = 6'h01;
    rd(8'h0C, 32'h0000_0001);
    // Item 6 does not exist, so its enable is refused
    for (i = 1; i < 7; i++)
    begin
      wr(8'h04, 32'(i));
      wr(8'h08, 32'h0000_0001);
    end
    mk = 6'h3F;
    rd(8'h0C, 32'h0000_003F);
    frame(4);
    frame(2);
    rd(8'h14, 32'h0000_0003);
    $display("test all items done");
    wr(8'h00, 32'h0000_0000);
    mm = 1'b0;
    mk = 6'h00;
    rd(8'h0C, 32'h0000_0000);
    frame(2);
    wr(8'h00, 32'h0000_0001);
    mm = 1'b1;
    mk = 6'h01;
    frame(3);
    $display("test switch toggle done");
    wr(8'h10, 32'h0000_0002);
    wr(8'h10, 32'h0000_0102);
    fx = 0;
    rd(8'h14, 32'h0000_0000);
    wr(8'h04, 32'h0000_0005);
    wr(8'h08, 32'h0000_0001);
    mk = 6'h21;
    frame(2);
    wr(8'h10, 32'h0000_0001);
    @(posedge clk);
    lines <= 8'hA5;
    fx = 0;
    rd(8'h14, 32'h0000_0000);
    wr(8'h10, 32'h0000_0100);
    frame(2);
    rd(8'h14, 32'h0000_0001);
    $display("test counter reset done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // One clock after release the stamp has advanced by three ticks
    rd(8'h18, 32'h0000_0003);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    $display("test second reset done");
    results();
  end
endmodule // icf_framer_tb
